// [dmi_pkg.sv]
// Constants shared by the data-move instruction unit.
package dmi_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int unsigned INSTR_W   = 14;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned PTR_W     = 16;
  localparam int unsigned FADDR_W   = 7;
  localparam int unsigned NUM_FILES = 128;
  localparam int unsigned BANK_W    = 5;
  localparam int unsigned LATCH_W   = 7;
  localparam int unsigned OFS_W     = 6;
  localparam int unsigned RADDR_W   = 4;

  // ==========================================================================
  // Opcode masks and patterns
  // ==========================================================================
  localparam logic [13:0] COPY_MASK  = 14'h3f00;
  localparam logic [13:0] COPY_PAT   = 14'h0800;
  localparam logic [13:0] STORE_MASK = 14'h3f80;
  localparam logic [13:0] STORE_PAT  = 14'h0080;
  localparam logic [13:0] IND_MASK   = 14'h3ff8;
  localparam logic [13:0] IND_PAT    = 14'h0010;
  localparam logic [13:0] OFS_MASK   = 14'h3f80;
  localparam logic [13:0] OFS_PAT    = 14'h3f00;
  localparam logic [13:0] BANK_MASK  = 14'h3fe0;
  localparam logic [13:0] BANK_PAT   = 14'h0020;
  localparam logic [13:0] LATCH_MASK = 14'h3f80;
  localparam logic [13:0] LATCH_PAT  = 14'h3180;
  localparam logic [13:0] ACC_MASK   = 14'h3f00;
  localparam logic [13:0] ACC_PAT    = 14'h3000;

  // ==========================================================================
  // Field positions and codes
  // ==========================================================================
  localparam int unsigned DEST_BIT     = 7;
  localparam int unsigned IND_SEL_BIT  = 2;
  localparam int unsigned OFS_SEL_BIT  = 6;
  localparam logic [1:0]  MODE_PRE_INC = 2'h0;
  localparam logic [1:0]  MODE_PRE_DEC = 2'h1;
  localparam logic [1:0]  MODE_POST_INC = 2'h2;
  localparam logic [5:0]  VIRT_HI      = 6'h00;

  // ==========================================================================
  // Register port offsets and reset values
  // ==========================================================================
  localparam logic [3:0] REG_ACC     = 4'h0;
  localparam logic [3:0] REG_STATUS  = 4'h1;
  localparam logic [3:0] REG_BANK    = 4'h2;
  localparam logic [3:0] REG_LATCH   = 4'h3;
  localparam logic [3:0] REG_P0_LO   = 4'h4;
  localparam logic [3:0] REG_P0_HI   = 4'h5;
  localparam logic [3:0] REG_P1_LO   = 4'h6;
  localparam logic [3:0] REG_P1_HI   = 4'h7;
  localparam logic [3:0] REG_F_INDEX = 4'h8;
  localparam logic [3:0] REG_F_DATA  = 4'h9;
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [15:0] RST_PTR    = 16'h0000;

  typedef enum logic [2:0] {
    DMI_OP_NONE, DMI_OP_COPY, DMI_OP_STORE, DMI_OP_IND,
    DMI_OP_OFS, DMI_OP_BANK, DMI_OP_LATCH, DMI_OP_ACC
  } dmi_op_t;

endpackage : dmi_pkg

// [dmi_core.sv]
// Execution unit for the data-move instructions of a small 8-bit core.
`timescale 1ns/10ps
// What this block does
// - Copy-file moves file register to accumulator (d=0) or back to itself (d=1).
// - Copy-file sets zero flag from the moved value.
// - Indirect load address: mode 00 pointer+1, 01 pointer-1, else pointer.
// - Offset form addresses pointer plus signed six-bit constant, pointer unchanged.
// - After indirect load pointer is +1 for increments, -1 for decrements.
// - Index bit picks pointer; virtual indirect register accesses the pointed location.
// - Pointers are 16 bits and wrap on increment or decrement.
// - Bank literal loads the five-bit literal into the bank select register.
// - Latch literal loads seven bits into the program high latch, flags kept.
// - Accumulator literal loads eight bits in one cycle, flags kept.
// - Store writes accumulator to file register in one cycle, flags kept.
module dmi_core
  import dmi_pkg::*;
(
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic                         instr_valid,
  input  wire logic [dmi_pkg::INSTR_W-1:0]  instr,
  input  wire logic [dmi_pkg::RADDR_W-1:0]  reg_addr,
  input  wire logic [dmi_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [dmi_pkg::DATA_W-1:0]   reg_rdata,
  output logic      [dmi_pkg::DATA_W-1:0]   accumulator,
  output logic                              zero_flag,
  output logic      [dmi_pkg::BANK_W-1:0]   bank_select_register,
  output logic      [dmi_pkg::LATCH_W-1:0]  program_counter_high_latch
);
  import dmi_pkg::*;

  // ==========================================================================
  // Reset release
  // ==========================================================================
  logic             rst_meta_n;
  logic             rst_sync_n;
  dmi_op_t          op;
  logic [DATA_W-1:0]  file_mem [NUM_FILES];
  logic [PTR_W-1:0]   pointer_register [2];
  logic [FADDR_W-1:0] file_idx;
  logic [FADDR_W-1:0] direct_idx;
  logic [DATA_W-1:0]  file_rd;
  logic               ptr_sel;
  logic [1:0]         pointer_mode_code;
  logic [PTR_W-1:0]   sel_ptr;
  logic [PTR_W-1:0]   ofs_ext;
  logic [PTR_W-1:0]   eff_addr;
  logic [PTR_W-1:0]   next_ptr;
  logic               file_we;
  logic [DATA_W-1:0]  file_wdata;
  logic [FADDR_W-1:0] sw_idx;

  // The external reset is released through two flops so all state but the file store leaves reset together.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ==========================================================================
  // Decode
  // ==========================================================================
  // Fixed bits are matched exactly; every other bit is an operand field, so no form has spare bits.
  always_comb begin
    op = DMI_OP_NONE;
    if (instr_valid) begin
      if ((instr & COPY_MASK) == COPY_PAT) begin
        op = DMI_OP_COPY;
      end else if ((instr & STORE_MASK) == STORE_PAT) begin
        op = DMI_OP_STORE;
      end else if ((instr & IND_MASK) == IND_PAT) begin
        op = DMI_OP_IND;
      end else if ((instr & OFS_MASK) == OFS_PAT) begin
        op = DMI_OP_OFS;
      end else if ((instr & BANK_MASK) == BANK_PAT) begin
        op = DMI_OP_BANK;
      end else if ((instr & LATCH_MASK) == LATCH_PAT) begin
        op = DMI_OP_LATCH;
      end else if ((instr & ACC_MASK) == ACC_PAT) begin
        op = DMI_OP_ACC;
      end
    end
  end

  // ==========================================================================
  // Address generation
  // ==========================================================================
  // Pointer select, mode and offset come from fixed positions of the word.
  always_comb begin
    ptr_sel           = (op == DMI_OP_OFS) ? instr[OFS_SEL_BIT] : instr[IND_SEL_BIT];
    pointer_mode_code = instr[1:0];
    sel_ptr           = pointer_register[ptr_sel];
    ofs_ext           = {{(PTR_W-OFS_W){instr[OFS_W-1]}}, instr[OFS_W-1:0]};
  end

  // Effective address and the pointer's next value; 16-bit sums wrap by width.
  always_comb begin
    eff_addr = sel_ptr;
    next_ptr = sel_ptr;
    if (op == DMI_OP_OFS) begin
      eff_addr = sel_ptr + ofs_ext;
    end else begin
      case (pointer_mode_code)
        MODE_PRE_INC: begin
          eff_addr = sel_ptr + 16'h0001;
          next_ptr = sel_ptr + 16'h0001;
        end
        MODE_PRE_DEC: begin
          eff_addr = sel_ptr - 16'h0001;
          next_ptr = sel_ptr - 16'h0001;
        end
        MODE_POST_INC: begin
          next_ptr = sel_ptr + 16'h0001;
        end
        default: begin
          next_ptr = sel_ptr - 16'h0001;
        end
      endcase
    end
  end

  // Direct accesses to files 0 and 1 go instead to the location a pointer names.
  // Only the low seven address bits reach the small file store, so data wraps by 128.
  always_comb begin
    direct_idx = instr[FADDR_W-1:0];
    if (op == DMI_OP_IND || op == DMI_OP_OFS) begin
      file_idx = eff_addr[FADDR_W-1:0];
    end else if (direct_idx[FADDR_W-1:1] == VIRT_HI) begin
      file_idx = pointer_register[direct_idx[0]][FADDR_W-1:0];
    end else begin
      file_idx = direct_idx;
    end
    file_rd = file_mem[file_idx];
  end

  // ==========================================================================
  // File store
  // ==========================================================================
  // An instruction write wins over a software write in the same cycle.
  always_comb begin
    file_we    = 1'b0;
    file_wdata = accumulator;
    if (op == DMI_OP_STORE) begin
      file_we = 1'b1;
    end else if (op == DMI_OP_COPY && instr[DEST_BIT]) begin
      file_we    = 1'b1;
      file_wdata = file_rd;
    end
  end

  // Storage has no reset; contents are undefined until written.
  always_ff @(posedge clk) begin
    if (file_we) begin
      file_mem[file_idx] <= file_wdata;
    end else if (reg_wr && reg_addr == REG_F_DATA) begin
      file_mem[sw_idx] <= reg_wdata;
    end
  end

  // Software index into the file store for inspection.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sw_idx <= RST_BYTE[FADDR_W-1:0];
    end else if (reg_wr && reg_addr == REG_F_INDEX) begin
      sw_idx <= reg_wdata[FADDR_W-1:0];
    end
  end

  // ==========================================================================
  // Working registers
  // ==========================================================================
  // Accumulator: instruction loads take priority over software writes.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      accumulator <= RST_BYTE;
    end else if (op == DMI_OP_COPY && !instr[DEST_BIT]) begin
      accumulator <= file_rd;
    end else if (op == DMI_OP_IND || op == DMI_OP_OFS) begin
      accumulator <= file_rd;
    end else if (op == DMI_OP_ACC) begin
      accumulator <= instr[DATA_W-1:0];
    end else if (reg_wr && reg_addr == REG_ACC) begin
      accumulator <= reg_wdata;
    end
  end

  // Zero flag follows moved data and software status writes; literal loads and stores leave it alone.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      zero_flag <= 1'b0;
    end else if (op == DMI_OP_COPY) begin
      zero_flag <= (file_rd == RST_BYTE);
    end else if (op == DMI_OP_IND || op == DMI_OP_OFS) begin
      zero_flag <= (file_rd == RST_BYTE);
    end else if (reg_wr && reg_addr == REG_STATUS) begin
      zero_flag <= reg_wdata[0];
    end
  end

  // Bank select keeps all five bits of the literal even though only 0 to 15 are meaningful.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      bank_select_register <= RST_BYTE[BANK_W-1:0];
    end else if (op == DMI_OP_BANK) begin
      bank_select_register <= instr[BANK_W-1:0];
    end else if (reg_wr && reg_addr == REG_BANK) begin
      bank_select_register <= reg_wdata[BANK_W-1:0];
    end
  end

  // Program counter high latch.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      program_counter_high_latch <= RST_BYTE[LATCH_W-1:0];
    end else if (op == DMI_OP_LATCH) begin
      program_counter_high_latch <= instr[LATCH_W-1:0];
    end else if (reg_wr && reg_addr == REG_LATCH) begin
      program_counter_high_latch <= reg_wdata[LATCH_W-1:0];
    end
  end

  // ==========================================================================
  // Pointer registers
  // ==========================================================================
  // Each pointer takes its step only when selected by an indirect load.
  for (genvar p = 0; p < 2; p++) begin : g_ptr
    localparam logic [3:0] LO = (p == 0) ? REG_P0_LO : REG_P1_LO;
    localparam logic [3:0] HI = (p == 0) ? REG_P0_HI : REG_P1_HI;
    always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        pointer_register[p] <= RST_PTR;
      end else if (op == DMI_OP_IND && ptr_sel == 1'(p)) begin
        pointer_register[p] <= next_ptr;
      end else if (reg_wr && reg_addr == LO) begin
        pointer_register[p][7:0] <= reg_wdata;
      end else if (reg_wr && reg_addr == HI) begin
        pointer_register[p][15:8] <= reg_wdata;
      end
    end
  end

  // ==========================================================================
  // Register read port
  // ==========================================================================
  // Read data stand the cycle after the strobe; other cycles and unmapped offsets give zero.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata <= RST_BYTE;
    end else if (!reg_rd) begin
      reg_rdata <= RST_BYTE;
    end else begin
      case (reg_addr)
        REG_ACC:     reg_rdata <= accumulator;
        REG_STATUS:  reg_rdata <= {7'h00, zero_flag};
        REG_BANK:    reg_rdata <= {3'h0, bank_select_register};
        REG_LATCH:   reg_rdata <= {1'h0, program_counter_high_latch};
        REG_P0_LO:   reg_rdata <= pointer_register[0][7:0];
        REG_P0_HI:   reg_rdata <= pointer_register[0][15:8];
        REG_P1_LO:   reg_rdata <= pointer_register[1][7:0];
        REG_P1_HI:   reg_rdata <= pointer_register[1][15:8];
        REG_F_INDEX: reg_rdata <= {1'h0, sw_idx};
        REG_F_DATA:  reg_rdata <= file_mem[sw_idx];
        default:     reg_rdata <= RST_BYTE;
      endcase
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  copy_to_acc_a: assert property (
    (op == DMI_OP_COPY && !instr[DEST_BIT]) |=> accumulator == $past(file_rd))
    else $error("Copy to accumulator lost the file value.");

  copy_zero_a: assert property (
    op == DMI_OP_COPY |=> zero_flag == ($past(file_rd) == 8'h00))
    else $error("Copy did not set zero flag from moved value.");

  ind_addr_a: assert property (
    (op == DMI_OP_IND && pointer_mode_code == MODE_PRE_DEC)
      |-> file_idx == 7'(pointer_register[instr[IND_SEL_BIT]] - 16'h0001))
    else $error("Predecrement address is wrong.");

  ofs_keep_a: assert property (
    op == DMI_OP_OFS && !(reg_wr && reg_addr[3:2] == 2'h1)
      |=> pointer_register[$past(ptr_sel)] == $past(sel_ptr))
    else $error("Offset load changed the pointer.");

  ptr_step_a: assert property (
    (op == DMI_OP_IND && !pointer_mode_code[0])
      |=> pointer_register[$past(ptr_sel)] == $past(sel_ptr) + 16'h0001)
    else $error("Increment mode did not advance the pointer.");

  virt_redirect_a: assert property (
    (op == DMI_OP_COPY && direct_idx == 7'h01) |-> file_idx == pointer_register[1][6:0])
    else $error("Virtual register not redirected through pointer.");

  ptr_wrap_a: assert property (
    (op == DMI_OP_IND && pointer_mode_code[0] && sel_ptr == 16'h0000)
      |=> pointer_register[$past(ptr_sel)] == 16'hffff)
    else $error("Pointer did not wrap below zero.");

  bank_load_a: assert property (
    op == DMI_OP_BANK |=> bank_select_register == $past(instr[4:0]))
    else $error("Bank select not loaded from literal.");

  latch_load_a: assert property (
    op == DMI_OP_LATCH |=> program_counter_high_latch == $past(instr[6:0]) && $stable(zero_flag))
    else $error("High latch load wrong or flag disturbed.");

  acc_literal_a: assert property (
    op == DMI_OP_ACC |=> accumulator == $past(instr[7:0]) && $stable(zero_flag))
    else $error("Accumulator literal wrong or flag disturbed.");

  store_acc_a: assert property (
    op == DMI_OP_STORE |=> file_mem[$past(file_idx)] == $past(accumulator) && $stable(zero_flag))
    else $error("Store did not write accumulator or disturbed flag.");

  ind_zero_a: assert property (
    (op == DMI_OP_IND || op == DMI_OP_OFS) |=> zero_flag == (accumulator == 8'h00))
    else $error("Indirect load zero flag mismatch.");

endmodule : dmi_core

// [test_data_move_instructions.sv]
// Self-checking testbench for the data-move instruction unit.
`timescale 1ns/10ps
module test_data_move_instructions;
  import dmi_pkg::*;

  // ==========================================================================
  // Signals
  // ==========================================================================
  logic               clk;
  logic               rst_n;
  logic               instr_valid;
  logic [INSTR_W-1:0] instr;
  logic [RADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0]  reg_wdata;
  logic               reg_wr;
  logic               reg_rd;
  logic [DATA_W-1:0]  reg_rdata;
  logic [DATA_W-1:0]  accumulator;
  logic               zero_flag;
  logic [BANK_W-1:0]  bank_select_register;
  logic [LATCH_W-1:0] program_counter_high_latch;
  int                 fail_count;
  int                 n_compared;
  int                 cycles;
  logic [31:0]        seed;

  dmi_core i_dut (
    .clk                        (clk),
    .rst_n                      (rst_n),
    .instr_valid                (instr_valid),
    .instr                      (instr),
    .reg_addr                   (reg_addr),
    .reg_wdata                  (reg_wdata),
    .reg_wr                     (reg_wr),
    .reg_rd                     (reg_rd),
    .reg_rdata                  (reg_rdata),
    .accumulator                (accumulator),
    .zero_flag                  (zero_flag),
    .bank_select_register       (bank_select_register),
    .program_counter_high_latch (program_counter_high_latch)
  );

  // ==========================================================================
  // Clock and hang guard
  // ==========================================================================
  // A 40 ns period gives the 25 MHz core clock.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // The tests need about 500 cycles, so 10000 only trips on a real hang.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      fail_count++;
      $display("MISMATCH at %0t: timeout", $time);
      complete_run();
    end
  end

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Address used by an indirect load: pre-modes move first, post-modes do not.
  function automatic logic [15:0] exp_addr(input logic [15:0] p, input logic [1:0] mm);
    if (mm == MODE_PRE_INC) begin
      return p + 16'h0001;
    end
    if (mm == MODE_PRE_DEC) begin
      return p - 16'h0001;
    end
    return p;
  endfunction : exp_addr

  // Pointer after the load; the low mode bit selects decrement.
  function automatic logic [15:0] exp_ptr(input logic [15:0] p, input logic [1:0] mm);
    return mm[0] ? p - 16'h0001 : p + 16'h0001;
  endfunction : exp_ptr

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_val

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : reg_write

  // Read data stand only in the cycle after the strobe, so sample just past that edge.
  task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read

  task automatic exec(input logic [13:0] w);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr       <= w;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
  endtask : exec

  task automatic file_write(input logic [6:0] f, input logic [7:0] v);
    reg_write(REG_F_INDEX, {1'b0, f});
    reg_write(REG_F_DATA, v);
  endtask : file_write

  task automatic file_read(input logic [6:0] f, output logic [7:0] v);
    reg_write(REG_F_INDEX, {1'b0, f});
    reg_read(REG_F_DATA, v);
  endtask : file_read

  task automatic set_ptr(input logic n, input logic [15:0] p);
    reg_write(n ? REG_P1_LO : REG_P0_LO, p[7:0]);
    reg_write(n ? REG_P1_HI : REG_P0_HI, p[15:8]);
  endtask : set_ptr

  task automatic get_ptr(input logic n, output logic [15:0] p);
    reg_read(n ? REG_P1_LO : REG_P0_LO, p[7:0]);
    reg_read(n ? REG_P1_HI : REG_P0_HI, p[15:8]);
  endtask : get_ptr

  task automatic complete_run();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    logic [31:0] r;
    logic [7:0]  v;
    logic [7:0]  a;
    logic [15:0] p;
    logic [15:0] q;
    logic [15:0] ea;
    logic [6:0]  f;
    logic [5:0]  k6;
    logic [1:0]  mm;
    logic        n;
    logic        z;
    rst_n = 1'b0; instr_valid = 1'b0; instr = '0; reg_addr = '0; reg_wdata = '0;
    reg_wr = 1'b0; reg_rd = 1'b0; seed = 32'h2edb2eb1;
    fail_count = 0; n_compared = 0; cycles = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    // Registers come up cleared; an unmapped offset reads 0 and ignores writes.
    for (int i = 0; i < 8; i++) begin
      reg_read(4'(i), v);
      check_val(16'(v), 16'h0000, "reset read");
    end
    reg_write(4'hf, 8'hff);
    reg_read(4'hf, v);
    check_val(16'(v), 16'h0000, "unmapped");
    // Software writes reach the working registers; read data fall back to zero a cycle later.
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      a = (i == 0) ? 8'hff : (i == 1) ? 8'h01 : (i == 2) ? 8'h1f : 8'h7f;
      reg_write(4'(i), r[7:0]);
      reg_read(4'(i), v);
      check_val(16'(v), 16'(r[7:0] & a), "sw write");
      @(posedge clk);
      #1;
      check_val(16'(reg_rdata), 16'h0000, "read idle");
    end
    $display("Test reset finished");
    // Accumulator literal over boundaries and random values.
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : r[7:0];
      z = zero_flag;
      exec(ACC_PAT | {6'h00, v});
      check_val(16'(accumulator), 16'(v), "acc literal");
      check_val(16'(zero_flag), 16'(z), "acc literal flag");
    end
    // Bank values 0 to 15, with latch boundary and random values.
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      f = (i == 0) ? 7'h00 : (i == 1) ? 7'h7f : r[6:0];
      z = zero_flag;
      exec(BANK_PAT | 14'(i));
      check_val(16'(bank_select_register), 16'(i), "bank");
      exec(LATCH_PAT | {7'h00, f});
      check_val(16'(program_counter_high_latch), 16'(f), "latch");
      check_val(16'(zero_flag), 16'(z), "latch flag");
    end
    $display("Test literals finished");
    // Store then copy back, alternating zero and non-zero data so the flag toggles.
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      f = (i == 0) ? 7'h7f : (i == 1) ? 7'h02 : 7'(2 + r[15:8] % 126);
      v = i[0] ? (r[7:0] | 8'h01) : 8'h00;
      exec(ACC_PAT | {6'h00, v});
      z = zero_flag;
      exec(STORE_PAT | {7'h00, f});
      check_val(16'(zero_flag), 16'(z), "store flag");
      file_read(f, a);
      check_val(16'(a), 16'(v), "store data");
      exec(ACC_PAT | {6'h00, ~v});
      exec(COPY_PAT | 14'h0080 | {7'h00, f});
      check_val(16'(accumulator), {8'h00, ~v}, "copy back acc");
      check_val(16'(zero_flag), 16'(v == 8'h00), "copy back flag");
      file_read(f, a);
      check_val(16'(a), 16'(v), "copy back file");
      exec(COPY_PAT | {7'h00, f});
      check_val(16'(accumulator), 16'(v), "copy to acc");
      check_val(16'(zero_flag), 16'(v == 8'h00), "copy flag");
    end
    $display("Test store and copy finished");
    // All pointer and mode pairs, two of them wrapping across the 16-bit range.
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      n = i[2];
      mm = i[1:0];
      p = (i == 2) ? 16'hffff : (i == 5) ? 16'h0000 : {r[31:23], 7'h40};
      v = i[0] ? 8'h00 : (r[7:0] | 8'h01);
      ea = exp_addr(p, mm);
      set_ptr(n, p);
      file_write(ea[6:0], v);
      exec(ACC_PAT | {6'h00, ~v});
      exec(IND_PAT | {11'h000, n, mm});
      check_val(16'(accumulator), 16'(v), "indirect acc");
      check_val(16'(zero_flag), 16'(v == 8'h00), "indirect flag");
      get_ptr(n, q);
      check_val(q, exp_ptr(p, mm), "indirect ptr");
    end
    // Offset form at both ends of the signed constant range.
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      n = i[0];
      k6 = (i == 0) ? 6'h20 : (i == 1) ? 6'h1f : r[13:8];
      p = {r[31:23], 7'h40};
      v = r[7:0];
      ea = p + {{10{k6[5]}}, k6};
      set_ptr(n, p);
      file_write(ea[6:0], v);
      exec(ACC_PAT | {6'h00, ~v});
      exec(OFS_PAT | {7'h00, n, k6});
      check_val(16'(accumulator), 16'(v), "offset acc");
      check_val(16'(zero_flag), 16'(v == 8'h00), "offset flag");
      get_ptr(n, q);
      check_val(q, p, "offset ptr");
    end
    $display("Test indirect finished");
    // Store and copy through each virtual indirect address.
    for (int i = 0; i < 2; i++) begin
      r = rnd();
      n = i[0];
      p = {r[31:23], 6'h28, n};
      v = r[7:0] | 8'h01;
      set_ptr(n, p);
      exec(ACC_PAT | {6'h00, v});
      exec(STORE_PAT | {13'h0000, n});
      file_read(p[6:0], a);
      check_val(16'(a), 16'(v), "virtual store");
      exec(ACC_PAT | {6'h00, ~v});
      exec(COPY_PAT | {13'h0000, n});
      check_val(16'(accumulator), 16'(v), "virtual copy");
      get_ptr(n, q);
      check_val(q, p, "virtual ptr");
    end
    $display("Test virtual finished");
    complete_run();
  end

endmodule : test_data_move_instructions
